/* File: src/srw_supervisor.sv */
// Operation
// [R1] Watchdog times out after 1.6 s with no toggle input edge.
// [R2] Any edge on toggle input clears watchdog counter.
// [R3] Watchdog timeout asserts reset on both reset pins.
// [R4] Watchdog counter held at zero while reset asserted.
// [R5] Write-protect high makes array read only, programming rejected.
// [R6] Write-protect low allows normal reads and writes.
// [R7] Hold resets until supply above threshold, then 200 ms more.
// [R8] After timeout release both reset pins to their pulls.
// [R9] Supply below threshold asserts both reset pins.
// [R10] Reset pins open-drain, only pulled toward asserted level.
// [R11] Externally forced reset level starts and holds own reset.
// [R12] Rising edge on active-high reset pin starts reset timeout.
// [R13] Falling edge on active-low reset pin starts reset timeout.
// [R14] Reset pin pulses under 100 ns are ignored.
// [R15] Program cycle starts at write stop, ends within 10 ms.
// [R16] During program cycle bus disabled, data released, address ignored.
// [R17] While reset asserted, ignore accesses and withhold acknowledge.
// [R18] Host waits 1 ms after supply stable before accessing.
// [R19] Serial clock and data filtered against 200 ns noise.
// [R20] Serial data driven only as open-drain output.
// [R21] All long timers run from the internal time base.
`timescale 1ns/10ps
`default_nettype none

module srw_supervisor #(
	parameter int unsigned WDOG_CYCLES  = srw_pkg::WDOG_CYCLES,
	parameter int unsigned PURST_CYCLES = srw_pkg::PURST_CYCLES,
	parameter int unsigned PROG_CYCLES  = srw_pkg::PROG_CYCLES
) (
	input  wire logic            core_clk,
	input  wire logic            rstn,
	input  wire logic            supplyOk,
	input  wire logic            watchdogToggleIn,
	input  wire logic            writeProtectIn,
	input  wire logic            resetHighIn,
	output logic                 resetHighOut,
	output logic                 resetHighOe,
	input  wire logic            resetLowIn,
	output logic                 resetLowOut,
	output logic                 resetLowOe,
	input  wire logic            sclIn,
	input  wire logic            sdaIn,
	output logic                 sdaOut,
	output logic                 sdaOe,
	input  wire logic            engSdaPull,
	input  wire logic            engAck,
	input  wire logic            engWriteStop,
	output logic                 sclFiltered,
	output logic                 sdaFiltered,
	output srw_pkg::srw_gate_s   memGate,
	output logic                 resetActive,
	output logic                 watchdogTimeout
);

	//////////////////////////////////////////////////////////////////////
	// Input synchronisers

	logic [1:0] wdSync_r;
	logic [1:0] wpSync_r;
	logic [1:0] supSync_r;
	logic [1:0] rhSync_r;
	logic [1:0] rlSync_r;
	logic [1:0] sclSync_r;
	logic [1:0] sdaSync_r;

	// Two flops on every pin
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			wdSync_r  <= 2'h0;
			wpSync_r  <= 2'h0;
			supSync_r <= 2'h0;
			rhSync_r  <= 2'h0;
			rlSync_r  <= 2'h3;
			sclSync_r <= 2'h3;
			sdaSync_r <= 2'h3;
		end else begin
			wdSync_r  <= {wdSync_r[0], watchdogToggleIn};
			wpSync_r  <= {wpSync_r[0], writeProtectIn};
			supSync_r <= {supSync_r[0], supplyOk};
			rhSync_r  <= {rhSync_r[0], resetHighIn};
			rlSync_r  <= {rlSync_r[0], resetLowIn};
			sclSync_r <= {sclSync_r[0], sclIn};
			sdaSync_r <= {sdaSync_r[0], sdaIn};
		end
	end

	//////////////////////////////////////////////////////////////////////
	// Glitch filters

	// Filter steps to the new level after a stable run of given length
	function automatic logic [srw_pkg::FLT_W:0] fltStep(
		input logic                    raw,
		input logic                    cur,
		input logic [srw_pkg::FLT_W-1:0] cnt,
		input logic [srw_pkg::FLT_W-1:0] lim
	);
		logic [srw_pkg::FLT_W:0] res;
		res = {cur, srw_pkg::FLT_RST};
		if (raw != cur) begin
			if (cnt >= lim - 4'h1) begin
				res = {raw, srw_pkg::FLT_RST};
			end else begin
				res = {cur, cnt + 4'h1};
			end
		end
		return res;
	endfunction : fltStep

	localparam logic [srw_pkg::FLT_W-1:0] GL_LIM = srw_pkg::FLT_W'(srw_pkg::GLITCH_CYCLES);
	localparam logic [srw_pkg::FLT_W-1:0] NS_LIM = srw_pkg::FLT_W'(srw_pkg::NOISE_CYCLES);

	logic [3:0]                   fltRaw;
	logic [3:0]                   fltLvl_r;
	logic [3:0][srw_pkg::FLT_W-1:0] fltCnt_r;

	assign fltRaw = {sdaSync_r[1], sclSync_r[1], rlSync_r[1], rhSync_r[1]};

	generate
		for (genvar i = 0; i < 4; i++) begin : g_flt
			logic [srw_pkg::FLT_W:0] stepNxt;
			// [R14] [R19] Pulse rejection
			assign stepNxt = fltStep(fltRaw[i], fltLvl_r[i], fltCnt_r[i],
				(i < 2) ? GL_LIM : NS_LIM);
			always_ff @(posedge core_clk) begin
				if (!rstn) begin
					fltLvl_r[i] <= (i == 0) ? 1'b0 : 1'b1;
					fltCnt_r[i] <= srw_pkg::FLT_RST;
				end else begin
					fltLvl_r[i] <= stepNxt[srw_pkg::FLT_W];
					fltCnt_r[i] <= stepNxt[srw_pkg::FLT_W-1:0];
				end
			end
		end
	endgenerate

	logic rhLvl;
	logic rlLvl;
	assign rhLvl       = fltLvl_r[0];
	assign rlLvl       = fltLvl_r[1];
	assign sclFiltered = fltLvl_r[2];
	assign sdaFiltered = fltLvl_r[3];

	//////////////////////////////////////////////////////////////////////
	// External reset and watchdog edge detect

	logic rhPrev_r;
	logic rlPrev_r;
	logic wdPrev_r;

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			rhPrev_r <= 1'b0;
			rlPrev_r <= 1'b1;
			wdPrev_r <= 1'b0;
		end else begin
			rhPrev_r <= rhLvl;
			rlPrev_r <= rlLvl;
			wdPrev_r <= wdSync_r[1];
		end
	end

	// Own drive takes sync plus filter time to leave the pin levels
	localparam logic [srw_pkg::FLT_W-1:0] ECHO_LAST =
		srw_pkg::FLT_W'(srw_pkg::GLITCH_CYCLES + 4);

	logic [srw_pkg::FLT_W-1:0] echoCnt_r;
	logic                      echoMask;
	logic                      rhRise;
	logic                      rlFall;
	logic                      extTrig;
	logic                      drivingReset;

	// Blank pin sensing while our own drive echoes back
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			echoCnt_r <= ECHO_LAST;
		end else if (drivingReset) begin
			echoCnt_r <= ECHO_LAST;
		end else if (echoCnt_r != srw_pkg::FLT_RST) begin
			echoCnt_r <= echoCnt_r - 4'h1;
		end
	end

	assign echoMask = drivingReset | (echoCnt_r != srw_pkg::FLT_RST);
	// [R12] [R13] Edges seen when not driving
	assign rhRise   = rhLvl & ~rhPrev_r & ~echoMask;
	assign rlFall   = ~rlLvl & rlPrev_r & ~echoMask;
	// [R11] Held level keeps reset
	assign extTrig  = rhRise | rlFall | ((rhLvl | ~rlLvl) & ~echoMask);

	//////////////////////////////////////////////////////////////////////
	// Supervisor state machine

	srw_pkg::srw_state_e state_r;
	srw_pkg::srw_state_e state_nxt;
	logic [srw_pkg::TMR_W-1:0] rstTmr_r;
	logic [srw_pkg::TMR_W-1:0] wdTmr_r;
	logic wdExpire;

	localparam logic [srw_pkg::TMR_W-1:0] PURST_LAST = srw_pkg::TMR_W'(PURST_CYCLES - 1);
	localparam logic [srw_pkg::TMR_W-1:0] WDOG_LAST  = srw_pkg::TMR_W'(WDOG_CYCLES - 1);
	localparam logic [srw_pkg::TMR_W-1:0] PROG_LAST  = srw_pkg::TMR_W'(PROG_CYCLES - 1);

	// Next state
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			srw_pkg::SRW_HOLD: begin
				// [R7] Wait for supply
				if (supSync_r[1]) begin
					state_nxt = srw_pkg::SRW_TIMEOUT;
				end
			end
			srw_pkg::SRW_TIMEOUT: begin
				// [R8] Release after timeout
				if (rstTmr_r == PURST_LAST) begin
					state_nxt = srw_pkg::SRW_RUN;
				end
			end
			srw_pkg::SRW_RUN: begin
				// [R3] Watchdog or outside trigger
				if (wdExpire || extTrig) begin
					state_nxt = srw_pkg::SRW_TIMEOUT;
				end
			end
		endcase
		// [R9] Brownout overrides everything
		if (!supSync_r[1]) begin
			state_nxt = srw_pkg::SRW_HOLD;
		end else if (state_r != srw_pkg::SRW_HOLD && (rhRise || rlFall)) begin
			state_nxt = srw_pkg::SRW_TIMEOUT;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			state_r <= srw_pkg::SRW_HOLD;
		end else begin
			state_r <= state_nxt;
		end
	end

	// [R21] Reset timeout counter, restarts on each entry
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			rstTmr_r <= srw_pkg::TMR_RST;
		end else if (state_r != srw_pkg::SRW_TIMEOUT || state_nxt != srw_pkg::SRW_TIMEOUT
			|| rhRise || rlFall) begin
			rstTmr_r <= srw_pkg::TMR_RST;
		end else begin
			rstTmr_r <= rstTmr_r + 27'h000_0001;
		end
	end

	assign resetActive  = (state_r != srw_pkg::SRW_RUN);
	assign drivingReset = resetActive;

	//////////////////////////////////////////////////////////////////////
	// Watchdog

	assign wdExpire = (wdTmr_r == WDOG_LAST);

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			wdTmr_r <= srw_pkg::TMR_RST;
		// [R4] Held cleared in reset
		end else if (resetActive) begin
			wdTmr_r <= srw_pkg::TMR_RST;
		// [R2] Edge clears counter
		end else if (wdSync_r[1] != wdPrev_r) begin
			wdTmr_r <= srw_pkg::TMR_RST;
		// [R1] Count toward timeout
		end else if (!wdExpire) begin
			wdTmr_r <= wdTmr_r + 27'h000_0001;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			watchdogTimeout <= 1'b0;
		end else begin
			watchdogTimeout <= wdExpire && !resetActive;
		end
	end

	//////////////////////////////////////////////////////////////////////
	// Program cycle

	logic                      progBusy_r;
	logic [srw_pkg::TMR_W-1:0] progTmr_r;

	// [R15] Start at write stop, finish at limit
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			progBusy_r <= 1'b0;
			progTmr_r  <= srw_pkg::TMR_RST;
		end else if (progBusy_r) begin
			progTmr_r <= progTmr_r + 27'h000_0001;
			if (progTmr_r == PROG_LAST) begin
				progBusy_r <= 1'b0;
				progTmr_r  <= srw_pkg::TMR_RST;
			end
		end else if (engWriteStop && !resetActive && !wpSync_r[1]) begin
			progBusy_r <= 1'b1;
		end
	end

	//////////////////////////////////////////////////////////////////////
	// Pin drive and gating

	// [R10] Drive only toward asserted level
	always_comb begin
		resetHighOut = 1'b1;
		resetLowOut  = 1'b0;
		resetHighOe  = resetActive;
		resetLowOe   = resetActive;
	end

	// [R16] [R17] Bus disabled in program cycle or reset
	assign memGate.busEnable    = ~progBusy_r & ~resetActive;
	// [R5] [R6] Write-protect gating
	assign memGate.writeAllowed = ~wpSync_r[1] & ~progBusy_r & ~resetActive;
	assign memGate.programBusy  = progBusy_r;

	// [R20] Open-drain data, low only
	assign sdaOut = 1'b0;
	assign sdaOe  = memGate.busEnable & (engSdaPull
		| (engAck & (memGate.writeAllowed | ~engWriteStop)));

endmodule : srw_supervisor

`default_nettype wire

/* File: src/srw_pkg.sv */
package srw_pkg;

	// Time base
	localparam int unsigned CLK_HZ = 50_000_000;
	localparam int unsigned CLK_NS = 20;

	// Watchdog period, typical, in ms
	localparam int unsigned WDOG_PERIOD_MS = 1600;
	localparam int unsigned WDOG_CYCLES = WDOG_PERIOD_MS * (CLK_HZ / 1000);

	// Power-up reset timeout, nominal, in ms
	localparam int unsigned PURST_MS = 200;
	localparam int unsigned PURST_CYCLES = PURST_MS * (CLK_HZ / 1000);

	// Program cycle, longest, in ms
	localparam int unsigned PROG_MS = 10;
	localparam int unsigned PROG_CYCLES = PROG_MS * (CLK_HZ / 1000);

	// Glitch reject width on reset pins, in ns (least, round up)
	localparam int unsigned GLITCH_NS = 100;
	localparam int unsigned GLITCH_CYCLES = (GLITCH_NS + CLK_NS - 1) / CLK_NS;

	// Noise suppression on serial inputs, in ns (least, round up)
	localparam int unsigned NOISE_NS = 200;
	localparam int unsigned NOISE_CYCLES = (NOISE_NS + CLK_NS - 1) / CLK_NS;

	// Counter widths
	localparam int unsigned TMR_W = 27;
	localparam int unsigned FLT_W = 4;

	// Reset values
	localparam logic [TMR_W-1:0] TMR_RST = 27'h000_0000;
	localparam logic [FLT_W-1:0] FLT_RST = 4'h0;

	// Supervisor states
	typedef enum logic [1:0] {
		SRW_HOLD,
		SRW_TIMEOUT,
		SRW_RUN
	} srw_state_e;

	// Open-drain pin as two signals
	typedef struct packed {
		logic drvOut;
		logic drvOe;
	} srw_od_s;

	// Memory port gating seen by the serial engine
	typedef struct packed {
		logic busEnable;
		logic writeAllowed;
		logic programBusy;
	} srw_gate_s;

endpackage : srw_pkg

/* File: tb/srw_supervisor_monitor.sv */
`timescale 1ns/10ps
`default_nettype none
module srw_supervisor_monitor #(
	parameter int unsigned WDOG_CYCLES = 200
) (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic supplyOk,
	input wire logic watchdogToggleIn,
	input wire logic writeProtectIn,
	input wire logic resetHighOut,
	input wire logic resetHighOe,
	input wire logic resetLowOut,
	input wire logic resetLowOe,
	input wire logic sdaOut,
	input wire logic sdaOe,
	input wire logic engWriteStop,
	input wire srw_pkg::srw_gate_s memGate,
	input wire logic resetActive,
	input wire logic watchdogTimeout
);
	logic [31:0] idleCnt_r;
	logic wdPrev_r;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rstn);
	// Idle cycles since a toggle or a reset
	always_ff @(posedge core_clk) begin
		wdPrev_r <= watchdogToggleIn;
		if (!rstn || resetActive || watchdogToggleIn != wdPrev_r)
			idleCnt_r <= '0;
		else
			idleCnt_r <= idleCnt_r + 1;
	end
	sequence supplyGone; $fell(supplyOk); endsequence
	sequence bothDriven; ##[1:5] (resetHighOe && resetLowOe); endsequence
	brownout_reset_a: assert property (supplyGone |-> bothDriven)
		else $error("no reset after supply loss");
	wd_period_a: assert property (watchdogTimeout |->
		idleCnt_r + 2 >= WDOG_CYCLES && idleCnt_r <= WDOG_CYCLES + 8)
		else $error("watchdog period wrong");
	wd_reset_a: assert property (watchdogTimeout |-> ##[0:2] resetHighOe)
		else $error("no reset after watchdog");
	wd_held_a: assert property (resetActive [*3] |=> !watchdogTimeout)
		else $error("watchdog ran in reset");
	pin_levels_a: assert property (resetHighOut && !resetLowOut)
		else $error("reset pin drive level wrong");
	oe_pair_a: assert property (resetHighOe == resetLowOe)
		else $error("reset pins differ");
	sda_od_a: assert property (!sdaOut)
		else $error("data line driven high");
	reset_gate_a: assert property (resetActive |-> !memGate.busEnable && !sdaOe)
		else $error("bus live in reset");
	prog_gate_a: assert property (memGate.programBusy |-> !memGate.busEnable && !sdaOe)
		else $error("bus live while busy");
	wp_block_a: assert property (writeProtectIn [*4] |-> !memGate.writeAllowed)
		else $error("write allowed under protect");
endmodule : srw_supervisor_monitor
`default_nettype wire

/* File: tb/srw_host_model.sv */
`timescale 1ns/10ps
`default_nettype none
module srw_host_model #(
	parameter int KICK = 40
) (
	input wire logic core_clk,
	input wire logic kickEn,
	input wire logic forceHigh,
	input wire logic forceLow,
	input wire logic pullSda,
	input wire logic resetHighOe,
	input wire logic resetLowOe,
	input wire logic sdaOe,
	output logic watchdogToggleIn,
	output logic resetHighIn,
	output logic resetLowIn,
	output logic sdaIn
);
	logic wdTog_r = 1'b0;
	int kickCnt_r = 0;
	// Toggle the watchdog line every KICK cycles
	always @(posedge core_clk) begin
		kickCnt_r <= (kickCnt_r == KICK - 1) ? 0 : kickCnt_r + 1;
		if (kickEn && kickCnt_r == KICK - 1)
			wdTog_r <= ~wdTog_r;
	end
	// Wired lines with pull-down, pull-up, pull-up
	assign watchdogToggleIn = wdTog_r;
	assign resetHighIn = resetHighOe | forceHigh;
	assign resetLowIn = ~(resetLowOe | forceLow);
	assign sdaIn = ~(sdaOe | pullSda);
endmodule : srw_host_model
`default_nettype wire

/* File: tb/srw_supervisor_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module srw_supervisor_tb;
	localparam int WD = 200;
	localparam int PU = 100;
	localparam int PG = 50;
	logic core_clk = 1'b0;
	logic rstn = 1'b0;
	logic supplyOk = 1'b0;
	logic wp = 1'b0;
	logic kickEn = 1'b0;
	logic fHi = 1'b0;
	logic fLo = 1'b0;
	logic pSda = 1'b0;
	logic sclIn = 1'b1;
	logic engPull = 1'b0;
	logic engAck = 1'b0;
	logic wStop = 1'b0;
	logic wdIn, rhIn, rhOe, rlIn, rlOe, sdaIn, sdaOe, sdaF, rAct, sclF, wdTo;
	srw_pkg::srw_gate_s gate;
	int bad_count = 0;
	int checks_done = 0;
	int cyc = 0;
	int n;
	always #10 core_clk = ~core_clk;
	srw_supervisor #(.WDOG_CYCLES(WD), .PURST_CYCLES(PU), .PROG_CYCLES(PG)) DUT (
		.core_clk(core_clk), .rstn(rstn), .supplyOk(supplyOk),
		.watchdogToggleIn(wdIn), .writeProtectIn(wp), .resetHighIn(rhIn),
		.resetHighOut(), .resetHighOe(rhOe), .resetLowIn(rlIn), .resetLowOut(),
		.resetLowOe(rlOe), .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(), .sdaOe(sdaOe),
		.engSdaPull(engPull), .engAck(engAck), .engWriteStop(wStop), .sclFiltered(sclF),
		.sdaFiltered(sdaF), .memGate(gate), .resetActive(rAct), .watchdogTimeout(wdTo));
	srw_host_model host (.core_clk(core_clk), .kickEn(kickEn), .forceHigh(fHi),
		.forceLow(fLo), .pullSda(pSda), .resetHighOe(rhOe), .resetLowOe(rlOe),
		.sdaOe(sdaOe), .watchdogToggleIn(wdIn), .resetHighIn(rhIn),
		.resetLowIn(rlIn), .sdaIn(sdaIn));
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			bad_count++;
			$display("[FAIL] %s expected %0h seen %0h", nm, exp, seen);
		end
	endtask : chk
	task automatic tick(input int k);
		repeat (k) @(posedge core_clk);
	endtask : tick
	task automatic relWait(output int k);
		k = 0;
		while (rhOe !== 1'b0 && k < 2000) begin
			tick(1);
			k++;
		end
	endtask : relWait
	task automatic stopPulse;
		wStop <= 1'b1;
		tick(1);
		wStop <= 1'b0;
		tick(3);
	endtask : stopPulse
	task automatic drvPin(input bit hi, input logic v);
		if (hi) fHi <= v;
		else fLo <= v;
	endtask : drvPin
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : report_and_stop
	// Power-up hold and timeout
	task automatic t_powerup;
		tick(20);
		chk("hold", {rhOe, rlOe}, 2'b11);
		supplyOk <= 1'b1;
		relWait(n);
		chk("purst", n >= PU && n <= PU + 6, 1);
		chk("released", {rhIn, rlIn}, 2'b01);
		$display("power-up test done");
	endtask : t_powerup
	// Watchdog fed, then starved
	task automatic t_watchdog;
		kickEn <= 1'b1;
		n = 0;
		repeat (3 * WD) begin
			tick(1);
			n += int'(rAct === 1'b1);
		end
		chk("fedWd", n, 0);
		@(wdIn);
		tick(1);
		kickEn <= 1'b0;
		n = 0;
		while (rAct !== 1'b1 && n < 3 * WD) begin
			tick(1);
			n++;
		end
		chk("wdPeriod", n + 2 >= WD && n <= WD + 8, 1);
		chk("wdFlag", wdTo, 1);
		chk("wdPins", {rhIn, rlIn}, 2'b10);
		relWait(n);
		chk("wdRelease", n <= PU + 4, 1);
		tick(WD / 2);
		chk("wdHeld", rAct, 0);
		kickEn <= 1'b1;
		$display("watchdog test done");
	endtask : t_watchdog
	// Serial input noise filter
	task automatic t_noise;
		engPull <= 1'b1;
		tick(3);
		chk("sdaDrive", sdaOe, 1);
		engPull <= 1'b0;
		tick(15);
		pSda <= 1'b1;
		sclIn <= 1'b0;
		tick(5);
		pSda <= 1'b0;
		sclIn <= 1'b1;
		tick(4);
		chk("noise", {sclF, sdaF}, 2'b11);
		tick(10);
		pSda <= 1'b1;
		sclIn <= 1'b0;
		tick(14);
		chk("noisePass", {sclF, sdaF}, 2'b00);
		pSda <= 1'b0;
		sclIn <= 1'b1;
		tick(14);
		chk("noiseBack", {sclF, sdaF}, 2'b11);
		$display("noise test done");
	endtask : t_noise
	// Program cycle and write protect
	task automatic t_write;
		// First write long after supply up
		tick(4);
		chk("wrOpen", gate.writeAllowed, 1);
		stopPulse();
		chk("busyGate", {gate.programBusy, gate.busEnable}, 2'b10);
		n = 0;
		while (gate.programBusy === 1'b1 && n < 200) begin
			tick(1);
			n++;
		end
		chk("progLen", n + 6 >= PG && n <= PG, 1);
		wp <= 1'b1;
		tick(4);
		chk("wrShut", gate.writeAllowed, 0);
		engAck <= 1'b1;
		wStop <= 1'b1;
		tick(1);
		chk("wpNoAck", sdaOe, 0);
		wStop <= 1'b0;
		tick(1);
		chk("addrAck", sdaOe, 1);
		engAck <= 1'b0;
		tick(3);
		chk("noProg", gate.programBusy, 0);
		wp <= 1'b0;
		$display("write test done");
	endtask : t_write
	// Manual reset through either pin
	task automatic t_manual(input bit hi);
		tick(20);
		drvPin(hi, 1'b1);
		tick(3);
		drvPin(hi, 1'b0);
		tick(10);
		chk("glitch", rAct, 0);
		drvPin(hi, 1'b1);
		tick(20);
		chk("forced", {rAct, rhIn, rlIn}, 3'b110);
		drvPin(hi, 1'b0);
		relWait(n);
		chk("manRelease", n > 0 && n <= PU + 10, 1);
		$display("manual test done");
	endtask : t_manual
	// Brownout while the bus engine is active
	task automatic t_brownout;
		tick(20);
		engPull <= 1'b1;
		supplyOk <= 1'b0;
		tick(6);
		chk("brownout", {rhOe, rlOe, gate.busEnable, sdaOe}, 4'b1100);
		supplyOk <= 1'b1;
		engPull <= 1'b0;
		relWait(n);
		chk("brownRelease", n >= PU && n <= PU + 6, 1);
		$display("brownout test done");
	endtask : t_brownout
	// Cycle timeout
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 5000) begin
			bad_count++;
			report_and_stop();
		end
	end
	// Main sequence
	initial begin
		tick(12);
		rstn <= 1'b1;
		t_powerup();
		t_watchdog();
		t_noise();
		t_write();
		t_manual(1'b1);
		t_manual(1'b0);
		t_brownout();
		report_and_stop();
	end
endmodule : srw_supervisor_tb
bind srw_supervisor srw_supervisor_monitor #(.WDOG_CYCLES(WDOG_CYCLES)) mon (
	.core_clk(core_clk), .rstn(rstn), .supplyOk(supplyOk),
	.watchdogToggleIn(watchdogToggleIn), .writeProtectIn(writeProtectIn),
	.resetHighOut(resetHighOut), .resetHighOe(resetHighOe), .resetLowOut(resetLowOut),
	.resetLowOe(resetLowOe), .sdaOut(sdaOut), .sdaOe(sdaOe), .engWriteStop(engWriteStop),
	.memGate(memGate), .resetActive(resetActive), .watchdogTimeout(watchdogTimeout));
`default_nettype wire
